// file: shared/ucb_params.svh
`ifndef UCB_PARAMS_SVH
`define UCB_PARAMS_SVH

// ----------------------------------------
// register addresses
// ----------------------------------------
`define UCB_ENDPOINT_CONTROL_ADDR 8'hE1
`define UCB_ENDPOINT_SELECT_ADDR 8'hF1

// ----------------------------------------
// endpoint control field positions
// ----------------------------------------
`define UCB_BIT_RX_STALL 7
`define UCB_BIT_TX_STALL 6
`define UCB_BIT_CTL_EP 5
`define UCB_BIT_RX_SPM 4
`define UCB_BIT_RX_IE 3
`define UCB_BIT_RX_EPEN 2
`define UCB_BIT_TX_OE 1
`define UCB_BIT_TX_EPEN 0

// ----------------------------------------
// endpoint select field positions
// ----------------------------------------
`define UCB_BIT_HUB_SEL 7

// ----------------------------------------
// reset values and hard-wired control mask
// ----------------------------------------
`define UCB_RST_CTRL_EP0 8'h35
`define UCB_RST_CTRL_EPN 8'h10
`define UCB_RST_SELECT 8'h80
`define UCB_HARD_CTL_MASK 8'h30

// ----------------------------------------
// bank numbering and packet limits
// ----------------------------------------
`define UCB_NUM_BANKS 4
`define UCB_HUB_BANK 2'h3
`define UCB_MAX_PKTS_DUAL 2'h2
`define UCB_MAX_PKTS_SINGLE 2'h1

`endif

// file: shared/ucb_pkg.sv
package ucb_pkg;

  // token kinds, one-hot so a bad code is easy to spot
  typedef enum logic [2:0] {
    UCB_TOK_OUT   = 3'b001,
    UCB_TOK_IN    = 3'b010,
    UCB_TOK_SETUP = 3'b100
  } ucb_tok_kind_t;

  // handshake answer chosen for a token
  typedef enum logic [3:0] {
    UCB_RSP_NONE  = 4'b0001,
    UCB_RSP_ACK   = 4'b0010,
    UCB_RSP_NAK   = 4'b0100,
    UCB_RSP_STALL = 4'b1000
  } ucb_rsp_kind_t;

  // valid token from the serial engine
  typedef struct packed {
    logic valid;
    ucb_tok_kind_t kind;
    logic hub;
    logic [1:0] num;
  } ucb_token_t;

  // endpoint event (packet release or setup flag clear)
  typedef struct packed {
    logic valid;
    logic hub;
    logic [1:0] num;
  } ucb_ep_evt_t;

  // answer back to the serial engine
  typedef struct packed {
    logic valid;
    ucb_rsp_kind_t kind;
    logic fifo_write;
    logic send_data;
  } ucb_resp_t;

endpackage

// file: hdl/ucb_ep_bank.sv
module ucb_ep_bank #(
  parameter logic [7:0] RESET_VAL = 8'h10,
  parameter logic [7:0] HARD_ONES = 8'h00
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // firmware side
  input wire logic wr_en,
  input wire logic [7:0] wdata,
  input wire logic setup_clr,
  // token side and packet release
  input wire logic setup_set,
  input wire logic pkt_inc,
  input wire logic pkt_dec,
  // state out
  output logic [7:0] ctrl,
  output logic setup_flag,
  output logic [1:0] pkt_count
);
  import ucb_pkg::*;

  logic [7:0] ctrl_reg;
  logic [7:0] ctrl_next;
  logic setup_reg;
  logic setup_next;
  logic [1:0] pkt_reg;
  logic [1:0] pkt_next;

  // ----------------------------------------
  // next-state decode
  // ----------------------------------------
  // hard-wired ones survive any write
  assign ctrl_next = wr_en ? (wdata | HARD_ONES) : ctrl_reg;
  // a set in the same cycle as a clear wins, so no setup is lost
  assign setup_next = setup_set | (setup_reg & ~setup_clr);
  // simultaneous accept and release leaves the count unchanged
  assign pkt_next = (pkt_inc & ~pkt_dec & (pkt_reg != 2'h3)) ? pkt_reg + 2'h1 :
                    (pkt_dec & ~pkt_inc & (pkt_reg != 2'h0)) ? pkt_reg - 2'h1 :
                    pkt_reg;

  // ----------------------------------------
  // storage
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= RESET_VAL;
      setup_reg <= 1'b0;
      pkt_reg <= 2'h0;
    end else begin
      ctrl_reg <= ctrl_next;
      setup_reg <= setup_next;
      pkt_reg <= pkt_next;
    end
  end

  assign ctrl = ctrl_reg;
  assign setup_flag = setup_reg;
  assign pkt_count = pkt_reg;
endmodule

// file: hdl/ucb_token_decide.sv
`include "ucb_params.svh"

module ucb_token_decide (
  // endpoint state
  input wire logic [7:0] ctrl,
  input wire logic setup_flag,
  input wire logic [1:0] pkt_count,
  // token
  input wire ucb_pkg::ucb_tok_kind_t kind,
  // decision
  output ucb_pkg::ucb_rsp_kind_t rsp,
  output logic fifo_write,
  output logic send_data,
  output logic setup_take
);
  import ucb_pkg::*;

  logic rx_stall;
  logic tx_stall;
  logic ctl_ep;
  logic single;
  logic rx_ie;
  logic rx_en;
  logic tx_oe;
  logic tx_en;
  logic fifo_full;

  // ----------------------------------------
  // field taps
  // ----------------------------------------
  assign rx_stall = ctrl[`UCB_BIT_RX_STALL];
  assign tx_stall = ctrl[`UCB_BIT_TX_STALL];
  assign ctl_ep = ctrl[`UCB_BIT_CTL_EP];
  assign single = ctrl[`UCB_BIT_RX_SPM];
  assign rx_ie = ctrl[`UCB_BIT_RX_IE];
  assign rx_en = ctrl[`UCB_BIT_RX_EPEN];
  assign tx_oe = ctrl[`UCB_BIT_TX_OE];
  assign tx_en = ctrl[`UCB_BIT_TX_EPEN];
  // packet room depends on single or dual mode
  assign fifo_full = single ? (pkt_count >= `UCB_MAX_PKTS_SINGLE) :
                              (pkt_count >= `UCB_MAX_PKTS_DUAL);

  // ----------------------------------------
  // decision, priority top to bottom
  // ----------------------------------------
  always_comb begin
    rsp = UCB_RSP_NONE;
    fifo_write = 1'b0;
    send_data = 1'b0;
    setup_take = 1'b0;
    unique case (kind)
      UCB_TOK_OUT: begin
        if (!rx_en) begin
          rsp = UCB_RSP_NONE;
        end else if (rx_stall) begin
          rsp = setup_flag ? UCB_RSP_NAK : UCB_RSP_STALL;
        end else if (!rx_ie || fifo_full) begin
          rsp = UCB_RSP_NAK;
        end else begin
          rsp = UCB_RSP_ACK;
          fifo_write = 1'b1;
        end
      end
      UCB_TOK_SETUP: begin
        // stall and input enable are not looked at here
        if (rx_en && ctl_ep) begin
          rsp = UCB_RSP_ACK;
          fifo_write = 1'b1;
          setup_take = 1'b1;
        end
      end
      UCB_TOK_IN: begin
        if (!tx_en) begin
          rsp = UCB_RSP_NONE;
        end else if (tx_stall) begin
          rsp = setup_flag ? UCB_RSP_NAK : UCB_RSP_STALL;
        end else if (!tx_oe) begin
          rsp = UCB_RSP_NAK;
        end else begin
          send_data = 1'b1;
        end
      end
      default: begin
        rsp = UCB_RSP_NONE;
      end
    endcase
  end
endmodule

// file: hdl/ucb_endpoint_bank.sv
`include "ucb_params.svh"

module ucb_endpoint_bank #(
  parameter int NUM_BANKS = `UCB_NUM_BANKS
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // byte-wide register port from the core
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // token path from the serial engine
  input wire ucb_pkg::ucb_token_t token,
  output ucb_pkg::ucb_resp_t resp,
  // endpoint events from the fifo and firmware
  input wire ucb_pkg::ucb_ep_evt_t pkt_release,
  input wire ucb_pkg::ucb_ep_evt_t setup_clear,
  // status
  output logic [NUM_BANKS-1:0] setup_flags
);
  import ucb_pkg::*;

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  // endpoint select, only bit 7 and bits 1:0 are stored
  // reset image kept whole so each stored field is cut out at its own width
  localparam logic [7:0] SEL_RST = `UCB_RST_SELECT;
  logic sel_hub_reg;
  logic [1:0] sel_num_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  ucb_resp_t resp_reg;
  ucb_resp_t resp_next;
  logic [NUM_BANKS-1:0] setup_reg;

  // decoded bank for firmware and for tokens
  logic sel_ok;
  logic [1:0] sel_bank;
  logic tok_ok;
  logic [1:0] tok_bank;
  logic tok_hub_tx;
  logic rel_ok;
  logic [1:0] rel_bank;
  logic clr_ok;
  logic [1:0] clr_bank;

  // register strobes
  logic hit_ctrl;
  logic hit_sel;
  logic wr_ctrl;
  logic wr_sel;

  // per-bank state and decisions
  logic [7:0] bank_ctrl [NUM_BANKS];
  logic [NUM_BANKS-1:0] bank_setup;
  logic [1:0] bank_pkts [NUM_BANKS];
  ucb_rsp_kind_t bank_rsp [NUM_BANKS];
  logic [NUM_BANKS-1:0] bank_fifo_wr;
  logic [NUM_BANKS-1:0] bank_send;
  logic [NUM_BANKS-1:0] bank_take;

  // ----------------------------------------
  // endpoint decode
  // ----------------------------------------
  // function endpoints 0..2 use banks 0..2, hub endpoint 0 uses bank 3;
  // hub endpoint 1 only has a transmit data path, so no bank at all
  assign sel_ok = sel_hub_reg ? (sel_num_reg == 2'h0) : (sel_num_reg != 2'h3);
  assign sel_bank = sel_hub_reg ? `UCB_HUB_BANK : sel_num_reg;
  assign tok_ok = token.hub ? (token.num == 2'h0) : (token.num != 2'h3);
  assign tok_bank = token.hub ? `UCB_HUB_BANK : token.num;
  assign tok_hub_tx = token.valid & token.hub & (token.num == 2'h1);
  assign rel_ok = pkt_release.hub ? (pkt_release.num == 2'h0) : (pkt_release.num != 2'h3);
  assign rel_bank = pkt_release.hub ? `UCB_HUB_BANK : pkt_release.num;
  assign clr_ok = setup_clear.hub ? (setup_clear.num == 2'h0) : (setup_clear.num != 2'h3);
  assign clr_bank = setup_clear.hub ? `UCB_HUB_BANK : setup_clear.num;

  // ----------------------------------------
  // register address decode
  // ----------------------------------------
  // every access is one byte; there is no wider path to misuse
  assign hit_ctrl = (sfr_addr == `UCB_ENDPOINT_CONTROL_ADDR);
  assign hit_sel = (sfr_addr == `UCB_ENDPOINT_SELECT_ADDR);
  // writes to a missing bank are dropped, like any unmapped location
  assign wr_ctrl = sfr_wr & hit_ctrl & sel_ok;
  assign wr_sel = sfr_wr & hit_sel;

  // ----------------------------------------
  // endpoint banks and their decisions
  // ----------------------------------------
  for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
    localparam logic [1:0] BIDX = 2'(b);
    localparam logic [7:0] RVAL = (b == 0 || b == 3) ? `UCB_RST_CTRL_EP0 :
                                                      `UCB_RST_CTRL_EPN;
    localparam logic [7:0] HARD = (b == 3) ? `UCB_HARD_CTL_MASK : 8'h00;

    // one control register per endpoint pair
    ucb_ep_bank #(
      .RESET_VAL(RVAL),
      .HARD_ONES(HARD)
    ) u_bank (
      .clk(clk),
      .rst_n(rst_n),
      .wr_en(wr_ctrl & (sel_bank == BIDX)),
      .wdata(sfr_wdata),
      .setup_clr(setup_clear.valid & clr_ok & (clr_bank == BIDX)),
      .setup_set(token.valid & tok_ok & (tok_bank == BIDX) & bank_take[b]),
      .pkt_inc(token.valid & tok_ok & (tok_bank == BIDX) & bank_fifo_wr[b]),
      .pkt_dec(pkt_release.valid & rel_ok & (rel_bank == BIDX)),
      .ctrl(bank_ctrl[b]),
      .setup_flag(bank_setup[b]),
      .pkt_count(bank_pkts[b])
    );

    // the answer this endpoint would give to the current token
    ucb_token_decide u_decide (
      .ctrl(bank_ctrl[b]),
      .setup_flag(bank_setup[b]),
      .pkt_count(bank_pkts[b]),
      .kind(token.kind),
      .rsp(bank_rsp[b]),
      .fifo_write(bank_fifo_wr[b]),
      .send_data(bank_send[b]),
      .setup_take(bank_take[b])
    );
  end

  // ----------------------------------------
  // answer selection
  // ----------------------------------------
  // hub endpoint 1 has no control bits: IN always sends, else silence
  always_comb begin
    resp_next = '0;
    resp_next.kind = UCB_RSP_NONE;
    if (token.valid && tok_ok) begin
      resp_next.valid = 1'b1;
      resp_next.kind = bank_rsp[tok_bank];
      resp_next.fifo_write = bank_fifo_wr[tok_bank];
      resp_next.send_data = bank_send[tok_bank];
    end else if (tok_hub_tx && token.kind == UCB_TOK_IN) begin
      resp_next.valid = 1'b1;
      resp_next.send_data = 1'b1;
    end else if (token.valid) begin
      resp_next.valid = 1'b1;
    end
  end

  // ----------------------------------------
  // read data mux
  // ----------------------------------------
  // reserved select bits and missing banks read as zero
  assign rdata_next = !sfr_rd ? rdata_reg :
                      (hit_ctrl && sel_ok) ? bank_ctrl[sel_bank] :
                      hit_sel ? {sel_hub_reg, 5'h00, sel_num_reg} :
                      8'h00;

  // ----------------------------------------
  // endpoint select register
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_hub_reg <= SEL_RST[`UCB_BIT_HUB_SEL];
      sel_num_reg <= SEL_RST[1:0];
    end else if (wr_sel) begin
      sel_hub_reg <= sfr_wdata[`UCB_BIT_HUB_SEL];
      sel_num_reg <= sfr_wdata[1:0];
    end
  end

  // ----------------------------------------
  // registered outputs
  // ----------------------------------------
  // every answer comes one cycle after its token, from a flop
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= 8'h00;
      resp_reg <= '{valid: 1'b0, kind: UCB_RSP_NONE, fifo_write: 1'b0, send_data: 1'b0};
      setup_reg <= '0;
    end else begin
      rdata_reg <= rdata_next;
      resp_reg <= resp_next;
      setup_reg <= bank_setup;
    end
  end

  assign sfr_rdata = rdata_reg;
  assign resp = resp_reg;
  assign setup_flags = setup_reg;
endmodule

// file: sim/ucb_bank_properties.sv
module ucb_bank_properties #(
  parameter int NUM_BANKS = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register read port
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_rdata,
  // token path
  input wire ucb_pkg::ucb_token_t token,
  input wire ucb_pkg::ucb_resp_t resp,
  input wire logic [NUM_BANKS-1:0] setup_flags
);
  timeunit 1ns;
  timeprecision 1ps;
  import ucb_pkg::*;

  // ----
  // common clocking
  // ----
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // setup on function ep0 that was accepted
  sequence s_setup_ep0;
    token.valid && token.kind == UCB_TOK_SETUP && !token.hub && token.num == 2'h0
    ##1 resp.valid && resp.kind == UCB_RSP_ACK;
  endsequence

  a_setup_sets_flag: assert property (s_setup_ep0 |=> setup_flags[0])
    else $error("setup flag not set after accepted setup");
  a_resp_follows: assert property (token.valid |=> resp.valid)
    else $error("token without answer");
  a_no_spurious: assert property (!token.valid |=> !resp.valid)
    else $error("answer without token");
  a_setup_no_stall: assert property (token.valid && token.kind == UCB_TOK_SETUP |=>
    resp.kind inside {UCB_RSP_ACK, UCB_RSP_NONE} && !resp.send_data)
    else $error("setup answered with handshake other than ack");
  a_in_no_fifo: assert property (token.valid && token.kind == UCB_TOK_IN |=>
    !resp.fifo_write && resp.kind != UCB_RSP_ACK)
    else $error("in token wrote receive fifo");
  a_out_no_send: assert property (token.valid && token.kind == UCB_TOK_OUT |=>
    !resp.send_data)
    else $error("out token sent data");
  a_ack_writes_fifo: assert property (resp.valid && resp.kind == UCB_RSP_ACK |->
    resp.fifo_write)
    else $error("ack without fifo write");
  // setup_flags lags the flag the decision used by one cycle, so look one cycle on
  a_flag_gives_nak: assert property ((token.valid && token.kind != UCB_TOK_SETUP &&
    !token.hub && token.num != 2'h3) ##1 setup_flags[$past(token.num)] |->
    resp.kind != UCB_RSP_STALL)
    else $error("stall while setup flag set");
  a_hub_ep1_quiet: assert property (token.valid && token.hub && token.num == 2'h1 &&
    token.kind != UCB_TOK_IN |=> resp.kind == UCB_RSP_NONE && !resp.fifo_write)
    else $error("hub ep1 answered non-in token");
  a_rdata_holds: assert property (!sfr_rd |=> $stable(sfr_rdata))
    else $error("read data moved without read");
endmodule

bind ucb_endpoint_bank ucb_bank_properties #(.NUM_BANKS(NUM_BANKS)) ucb_bank_properties_inst (
  .clk(clk), .rst_n(rst_n), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
  .token(token), .resp(resp), .setup_flags(setup_flags));

// file: sim/ucb_host_model.sv
module ucb_host_model (
  // clock
  input wire logic clk,
  // token out, answer back
  output ucb_pkg::ucb_token_t token,
  input wire ucb_pkg::ucb_resp_t resp
);
  timeunit 1ns;
  timeprecision 1ps;
  import ucb_pkg::*;

  initial token = '0;

  // one token per call; a gap makes the host slow between tokens
  task automatic send(input ucb_tok_kind_t k, input logic h, input logic [1:0] n,
                      input int gap, output ucb_resp_t r);
    repeat (gap) @(posedge clk);
    @(posedge clk);
    token <= '{1'b1, k, h, n};
    @(posedge clk);
    // idle fields show the inverse so a stale decode cannot pass
    token <= '{1'b0, ucb_tok_kind_t'(~k), ~h, ~n};
    #1 r = resp;
  endtask
endmodule

// file: sim/ucb_tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ucb_pkg::*;
`include "ucb_params.svh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("wrong value at %0t got %h expected %h", $time, g, e); end end

  // ----
  // stimulus and observed signals
  // ----
  logic clk, rst_n, sfr_wr, sfr_rd;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
  ucb_token_t token;
  ucb_resp_t resp, r;
  ucb_ep_evt_t pkt_release, setup_clear;
  logic [3:0] setup_flags;
  int mismatches, total_checks;
  localparam logic [7:0] EC = `UCB_ENDPOINT_CONTROL_ADDR;
  localparam logic [7:0] ES = `UCB_ENDPOINT_SELECT_ADDR;

  ucb_endpoint_bank #(.NUM_BANKS(4)) ucb_endpoint_bank_inst (.clk(clk), .rst_n(rst_n),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .token(token), .resp(resp), .pkt_release(pkt_release),
    .setup_clear(setup_clear), .setup_flags(setup_flags));
  ucb_host_model ucb_host_model_inst (.clk(clk), .token(token), .resp(resp));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ----
  // byte-wide register access, one strobe cycle each
  // ----
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge clk);
    sfr_wr <= 1'b0;
    sfr_wdata <= ~d;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge clk);
    sfr_rd <= 1'b0;
    #1 `CHK(sfr_rdata, e)
  endtask

  // one token through the host model; fs is {fifo_write, send_data}
  task automatic tk(input ucb_tok_kind_t k, input logic [1:0] n, input ucb_rsp_kind_t ek,
                    input logic [1:0] fs, input logic h = 1'b0);
    ucb_host_model_inst.send(k, h, n, int'(n), r);
    `CHK(r.valid, 1'b1)
    `CHK(r.kind, ek)
    `CHK({r.fifo_write, r.send_data}, fs)
  endtask

  // c high clears the setup flag, low releases one packet
  task automatic ev(input logic c, input logic [1:0] n);
    @(posedge clk);
    setup_clear <= '{c, 1'b0, n};
    pkt_release <= '{!c, 1'b0, n};
    @(posedge clk);
    setup_clear <= '0;
    pkt_release <= '0;
  endtask

  task automatic done(input string s);
    $display("test %s done", s);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // under two hundred cycles are expected; far beyond that means a hang
  initial begin
    repeat (4000) @(posedge clk);
    mismatches++;
    tally_and_finish();
  end

  initial begin
    {rst_n, sfr_wr, sfr_rd, sfr_addr, sfr_wdata} = '0;
    {pkt_release, setup_clear} = '0;
    mismatches = 0;
    total_checks = 0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1 `CHK(setup_flags, 4'h0)
    rdc(ES, 8'h80);
    rdc(EC, 8'h35);
    for (int i = 0; i < 3; i++) begin
      wr(ES, 8'(i));
      rdc(EC, i == 0 ? 8'h35 : 8'h10);
    end
    wr(ES, 8'hFF);
    rdc(ES, 8'h83);
    wr(ES, 8'h81);
    wr(EC, 8'hFF);
    rdc(EC, 8'h00);
    wr(ES, 8'h80);
    wr(EC, 8'h00);
    rdc(EC, 8'h30);
    wr(ES, 8'h02);
    wr(EC, 8'hA5);
    rdc(EC, 8'hA5);
    rdc(8'hE0, 8'h00);
    done("registers");
    tk(UCB_TOK_OUT, 2'h0, UCB_RSP_NAK, 2'b00);
    tk(UCB_TOK_IN, 2'h0, UCB_RSP_NAK, 2'b00);
    tk(UCB_TOK_SETUP, 2'h0, UCB_RSP_ACK, 2'b10);
    @(posedge clk);
    #1 `CHK(setup_flags[0], 1'b1)
    wr(ES, 8'h00);
    wr(EC, 8'hF5);
    tk(UCB_TOK_OUT, 2'h0, UCB_RSP_NAK, 2'b00);
    tk(UCB_TOK_IN, 2'h0, UCB_RSP_NAK, 2'b00);
    tk(UCB_TOK_SETUP, 2'h0, UCB_RSP_ACK, 2'b10);
    ev(1'b1, 2'h0);
    tk(UCB_TOK_OUT, 2'h0, UCB_RSP_STALL, 2'b00);
    tk(UCB_TOK_IN, 2'h0, UCB_RSP_STALL, 2'b00);
    // stalls lifted only after the host has spoken to ep0
    wr(EC, 8'h3F);
    repeat (3) ev(1'b0, 2'h0);
    tk(UCB_TOK_OUT, 2'h0, UCB_RSP_ACK, 2'b10);
    tk(UCB_TOK_OUT, 2'h0, UCB_RSP_NAK, 2'b00);
    tk(UCB_TOK_IN, 2'h0, UCB_RSP_NONE, 2'b01);
    wr(EC, 8'h3A);
    tk(UCB_TOK_OUT, 2'h0, UCB_RSP_NONE, 2'b00);
    tk(UCB_TOK_SETUP, 2'h0, UCB_RSP_NONE, 2'b00);
    tk(UCB_TOK_IN, 2'h0, UCB_RSP_NONE, 2'b00);
    done("endpoint zero");
    wr(ES, 8'h01);
    wr(EC, 8'h0F);
    tk(UCB_TOK_OUT, 2'h1, UCB_RSP_ACK, 2'b10);
    tk(UCB_TOK_OUT, 2'h1, UCB_RSP_ACK, 2'b10);
    tk(UCB_TOK_OUT, 2'h1, UCB_RSP_NAK, 2'b00);
    ev(1'b0, 2'h1);
    tk(UCB_TOK_OUT, 2'h1, UCB_RSP_ACK, 2'b10);
    tk(UCB_TOK_SETUP, 2'h1, UCB_RSP_NONE, 2'b00);
    tk(UCB_TOK_IN, 2'h1, UCB_RSP_NONE, 2'b01, 1'b1);
    tk(UCB_TOK_OUT, 2'h1, UCB_RSP_NONE, 2'b00, 1'b1);
    done("other endpoints");
    // hub ep0: forced control and single-packet bits must act, not only read back
    wr(ES, 8'h80);
    wr(EC, 8'h0F);
    rdc(EC, 8'h3F);
    tk(UCB_TOK_SETUP, 2'h0, UCB_RSP_ACK, 2'b10, 1'b1);
    @(posedge clk);
    #1 `CHK(setup_flags, 4'h8)
    tk(UCB_TOK_OUT, 2'h0, UCB_RSP_NAK, 2'b00, 1'b1);
    done("hub endpoint zero");
    // a second reset in mid-run must bring back the setup flags, the select value and hub ep0 control
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1 `CHK(setup_flags, 4'h0)
    rdc(ES, 8'h80);
    rdc(EC, 8'h35);
    done("second reset");
    tally_and_finish();
  end
endmodule
